// ---- verilog/mpwm_pkg.sv ----
// Constants, register map and field carriers for the match based pulse modulator.
// Assumes a 32-bit APB slave port with byte addresses in the low eight bits.
package mpwm_pkg;
  // Sizes
  localparam int MPWM_MATCH_N = 7;
  localparam int MPWM_OUT_N = 6;
  localparam int MPWM_CAP_N = 2;
  localparam int MPWM_AW = 8;

  // Register byte offsets
  localparam logic [7:0] MPWM_CTRL_OFS = 8'h00;
  localparam logic [7:0] MPWM_COUNT_OFS = 8'h04;
  localparam logic [7:0] MPWM_PLIM_OFS = 8'h08;
  localparam logic [7:0] MPWM_PCNT_OFS = 8'h0C;
  localparam logic [7:0] MPWM_MCTRL_OFS = 8'h10;
  localparam logic [7:0] MPWM_MATCH0_OFS = 8'h14;
  localparam logic [7:0] MPWM_MATCH6_OFS = 8'h2C;
  localparam logic [7:0] MPWM_REL_OFS = 8'h30;
  localparam logic [7:0] MPWM_OCTRL_OFS = 8'h34;
  localparam logic [7:0] MPWM_CCTRL_OFS = 8'h38;
  localparam logic [7:0] MPWM_CAP0_OFS = 8'h3C;
  localparam logic [7:0] MPWM_CAP1_OFS = 8'h40;
  localparam logic [7:0] MPWM_CNT_OFS = 8'h44;
  localparam logic [7:0] MPWM_FLAG_OFS = 8'h48;

  // Values after reset
  localparam logic [31:0] MPWM_WORD_RST = 32'h0000_0000;
  localparam logic [3:0] MPWM_CTRL_RST = 4'h0;

  // Count source modes
  localparam logic [1:0] MPWM_SRC_TIMER = 2'h0;

  // Control word: bit0 run, bit1 hold clear, bit2 pulse mode, bit3 follower
  typedef struct packed {
    logic slave;
    logic pwm;
    logic clr;
    logic en;
  } mpwm_ctrl_type;

  // Action on match, three bits per match register
  typedef struct packed {
    logic stop;
    logic rst;
    logic irq;
  } mpwm_mact_type;

  // Capture channel setup, three bits per channel
  typedef struct packed {
    logic irq;
    logic fall;
    logic rise;
  } mpwm_cact_type;

  // Count source: bits 1:0 edge mode, bit 2 capture input select
  typedef struct packed {
    logic sel;
    logic [1:0] mode;
  } mpwm_src_type;
endpackage : mpwm_pkg

// ---- verilog/mpwm_edge.sv ----
// Edge detector for a capture input, rising and falling edges selectable.
// Assumes the input is already synchronous to pclk.
`timescale 1ns/100ps
module mpwm_edge (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sig,
  input wire logic rise_en,
  input wire logic fall_en,
  output logic evt
);
  logic prev_reg;

  // Previous level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= sig;
    end
  end

  // One cycle pulse on a selected edge
  assign evt = (sig & ~prev_reg & rise_en) | (~sig & prev_reg & fall_en);
endmodule : mpwm_edge

// ---- verilog/mpwm_prescale.sv ----
// Programmable 32-bit prescaler giving a one-cycle count step.
// Assumes step is a one-cycle enable from the count source.
`timescale 1ns/100ps
module mpwm_prescale
  import mpwm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic step,
  input wire logic [31:0] limit,
  output logic tick,
  output logic [31:0] pcount
);
  // Wrap point reached on a step
  assign tick = step & ~clear & (pcount == limit);

  // Prescale counter, restarts at zero at its limit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcount <= MPWM_WORD_RST;
    end else if (clear || tick) begin
      pcount <= MPWM_WORD_RST;
    end else if (step) begin
      pcount <= pcount + 32'h0000_0001;
    end
  end
endmodule : mpwm_prescale

// ---- verilog/mpwm_timer.sv ----
// Match based pulse modulator: timer, seven matches, six outputs, two captures.
// Assumes an APB master on pclk; capture and sync inputs synchronous to pclk.
// Behaviour
// - 32-bit count advanced through a 32-bit programmable prescaler.
// - Count source is pclk or selected edges of a capture input.
// - Seven match registers drive up to six single or three double outputs.
// - Each match may continue, stop or reset the count, optional flag.
// - Match zero sets the period and resets the count in pulse mode.
// - Single-edge outputs rise at cycle start unless held constantly low.
// - Each single-edge output uses one further match for its edge.
// - Double-edge outputs use two matches, rise and fall, either order.
// - All outputs share one period; widths are whole count steps.
// - In pulse mode new match values wait for software release, applied at cycle start.
// - Without pulse mode the block is a plain timer with match and capture.
// - Primary leads, secondary follows its run level for lockstep operation.
// - Selected capture edge copies the count into that capture register.
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
module mpwm_timer
  import mpwm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [MPWM_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [MPWM_CAP_N-1:0] cap_in,
  input wire logic sync_run_in,
  output logic sync_run_out,
  output logic [MPWM_OUT_N-1:0] pwm_out
);
  mpwm_ctrl_type ctrl_reg;
  mpwm_mact_type [MPWM_MATCH_N-1:0] mact_reg;
  mpwm_cact_type [MPWM_CAP_N-1:0] cact_reg;
  mpwm_src_type src_reg;
  logic [31:0] count_reg;
  logic [31:0] plim_reg;
  logic [31:0] pcount;
  logic [31:0] shadow_mem [MPWM_MATCH_N];
  logic [31:0] act_mem [MPWM_MATCH_N];
  logic [31:0] cap_mem [MPWM_CAP_N];
  logic [MPWM_MATCH_N-1:0] rel_reg;
  logic [MPWM_MATCH_N-1:0] rel_next;
  logic [MPWM_OUT_N-1:0] dbl_reg;
  logic [MPWM_OUT_N-1:0] oen_reg;
  logic [MPWM_MATCH_N+MPWM_CAP_N-1:0] flag_reg;
  logic [MPWM_MATCH_N+MPWM_CAP_N-1:0] flag_next;
  logic [31:0] rdata_reg;
  logic [31:0] rmux;
  logic [MPWM_OUT_N-1:0] out_reg;
  logic [MPWM_MATCH_N-1:0] hit;
  logic [MPWM_MATCH_N-1:0] rst_vec;
  logic [MPWM_MATCH_N-1:0] stop_vec;
  logic [MPWM_MATCH_N-1:0] irq_vec;
  logic [MPWM_CAP_N-1:0] cap_evt;
  logic [7:0] moff;
  logic [2:0] midx;
  logic is_match;
  logic addr_ok;
  logic wr_en;
  logic run;
  logic src_evt;
  logic step;
  logic tick;
  logic cycle_end;

  // APB handshake: zero wait, error on unmapped word
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign prdata = rdata_reg;
  assign wr_en = psel & penable & pwrite & addr_ok;

  // Match window decode
  assign moff = paddr - MPWM_MATCH0_OFS;
  assign midx = moff[4:2];
  assign is_match = (paddr >= MPWM_MATCH0_OFS) && (paddr <= MPWM_MATCH6_OFS)
                    && (paddr[1:0] == 2'h0);

  // Register read mux and map check
  always_comb begin
    addr_ok = 1'b1;
    rmux = MPWM_WORD_RST;
    if (is_match) begin
      rmux = shadow_mem[midx];
    end else begin
      unique case (paddr)
        MPWM_CTRL_OFS: rmux = {28'h000_0000, ctrl_reg};
        MPWM_COUNT_OFS: rmux = count_reg;
        MPWM_PLIM_OFS: rmux = plim_reg;
        MPWM_PCNT_OFS: rmux = pcount;
        MPWM_MCTRL_OFS: rmux = {11'h000, mact_reg};
        MPWM_REL_OFS: rmux = {25'h000_0000, rel_reg};
        MPWM_OCTRL_OFS: rmux = {16'h0000, 2'h0, oen_reg, 2'h0, dbl_reg};
        MPWM_CCTRL_OFS: rmux = {26'h000_0000, cact_reg};
        MPWM_CAP0_OFS: rmux = cap_mem[0];
        MPWM_CAP1_OFS: rmux = cap_mem[1];
        MPWM_CNT_OFS: rmux = {29'h0000_0000, src_reg};
        MPWM_FLAG_OFS: rmux = {23'h00_0000, flag_reg};
        default: addr_ok = 1'b0;
      endcase
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= MPWM_WORD_RST;
    end else if (psel && !penable) begin
      rdata_reg <= rmux;
    end
  end

  // stop on match
  // Control word; a stop match drops the run bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= MPWM_CTRL_RST;
    end else if (wr_en && paddr == MPWM_CTRL_OFS) begin
      ctrl_reg <= pwdata[3:0];
    end else if (|stop_vec) begin
      ctrl_reg.en <= 1'b0;
    end
  end

  // Setup registers written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      plim_reg <= MPWM_WORD_RST;
      mact_reg <= '0;
      dbl_reg <= '0;
      oen_reg <= '0;
      cact_reg <= '0;
      src_reg <= '0;
    end else if (wr_en) begin
      unique case (paddr)
        MPWM_PLIM_OFS: plim_reg <= pwdata;
        MPWM_MCTRL_OFS: mact_reg <= pwdata[20:0];
        MPWM_OCTRL_OFS: begin
          dbl_reg <= pwdata[5:0];
          oen_reg <= pwdata[13:8];
        end
        MPWM_CCTRL_OFS: cact_reg <= pwdata[5:0];
        MPWM_CNT_OFS: src_reg <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // follower run
  // A follower counts only while the leader runs
  assign run = ctrl_reg.en & (~ctrl_reg.slave | sync_run_in);
  assign sync_run_out = ctrl_reg.en;

  // count source
  // Edges of the selected capture input as count clock
  mpwm_edge u_src_edge (
    .pclk(pclk),
    .presetn(presetn),
    .sig(cap_in[src_reg.sel]),
    .rise_en(src_reg.mode[0]),
    .fall_en(src_reg.mode[1]),
    .evt(src_evt)
  );
  assign step = run & ((src_reg.mode == MPWM_SRC_TIMER) | src_evt);

  mpwm_prescale u_presc (
    .pclk(pclk),
    .presetn(presetn),
    .clear(ctrl_reg.clr),
    .step(step),
    .limit(plim_reg),
    .tick(tick),
    .pcount(pcount)
  );

  assign cycle_end = hit[0] & ctrl_reg.pwm;

  // count advance
  // Main count; resets on a reset match or the cycle end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= MPWM_WORD_RST;
    end else if (ctrl_reg.clr) begin
      count_reg <= MPWM_WORD_RST;
    end else if (tick) begin
      if ((|rst_vec) || cycle_end) begin
        count_reg <= MPWM_WORD_RST;
      end else begin
        count_reg <= count_reg + 32'h0000_0001;
      end
    end
  end

  // release bits
  // Pending releases; a new release wins over the cycle-end clear
  always_comb begin
    rel_next = rel_reg;
    if (cycle_end) begin
      rel_next = '0;
    end
    if (wr_en && paddr == MPWM_REL_OFS) begin
      rel_next = rel_next | pwdata[6:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rel_reg <= '0;
    end else begin
      rel_reg <= rel_next;
    end
  end

  // seven match registers
  // Per match register: shadow, active value and event terms
  for (genvar i = 0; i < MPWM_MATCH_N; i++) begin : g_match
    assign hit[i] = tick & (count_reg == act_mem[i]);
    assign rst_vec[i] = hit[i] & mact_reg[i].rst;
    assign stop_vec[i] = hit[i] & mact_reg[i].stop;
    assign irq_vec[i] = hit[i] & mact_reg[i].irq;

    // Software copy
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        shadow_mem[i] <= MPWM_WORD_RST;
      end else if (wr_en && is_match && midx == 3'(i)) begin
        shadow_mem[i] <= pwdata;
      end
    end

    // apply at cycle
    // Active value; plain timer mode takes writes at once
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        act_mem[i] <= MPWM_WORD_RST;
      end else if (wr_en && is_match && midx == 3'(i) && !ctrl_reg.pwm) begin
        act_mem[i] <= pwdata;
      end else if (cycle_end && rel_reg[i]) begin
        act_mem[i] <= shadow_mem[i];
      end
    end
  end

  // Per output: single edge rises at cycle start, double on its own match
  for (genvar n = 0; n < MPWM_OUT_N; n++) begin : g_out
    logic rise_ev;
    logic fall_ev;
    assign rise_ev = ((n > 0) && dbl_reg[n]) ? hit[n] : cycle_end;
    assign fall_ev = hit[n+1];

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        out_reg[n] <= 1'b0;
      end else if (!ctrl_reg.pwm || !oen_reg[n]) begin
        out_reg[n] <= 1'b0;
      end else if (fall_ev) begin
        out_reg[n] <= 1'b0;
      end else if (rise_ev) begin
        out_reg[n] <= 1'b1;
      end
    end
  end
  assign pwm_out = out_reg;

  // Capture channels
  for (genvar c = 0; c < MPWM_CAP_N; c++) begin : g_cap
    mpwm_edge u_cap_edge (
      .pclk(pclk),
      .presetn(presetn),
      .sig(cap_in[c]),
      .rise_en(cact_reg[c].rise),
      .fall_en(cact_reg[c].fall),
      .evt(cap_evt[c])
    );

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cap_mem[c] <= MPWM_WORD_RST;
      end else if (cap_evt[c]) begin
        cap_mem[c] <= count_reg;
      end
    end
  end

  // sticky flags
  // Write one clears; a new event in the same cycle wins
  always_comb begin
    flag_next = flag_reg;
    if (wr_en && paddr == MPWM_FLAG_OFS) begin
      flag_next = flag_reg & ~pwdata[8:0];
    end
    flag_next = flag_next | {cap_evt & {cact_reg[1].irq, cact_reg[0].irq}, irq_vec};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_count_hold: assert property (
    !tick && !ctrl_reg.clr |=> count_reg == $past(count_reg))
    else $error("count moved without a step");
  a_count_step: assert property (
    tick && !ctrl_reg.clr && !(|rst_vec) && !cycle_end
    |=> count_reg == $past(count_reg) + 32'h0000_0001)
    else $error("count did not advance on prescale wrap");
  a_presc_wrap: assert property (
    tick |=> pcount == 32'h0000_0000)
    else $error("prescaler did not restart");
  a_cycle_reset: assert property (
    cycle_end && !ctrl_reg.clr |=> count_reg == 32'h0000_0000)
    else $error("cycle match did not reset count");
  a_stop_match: assert property (
    (|stop_vec) && !(wr_en && paddr == MPWM_CTRL_OFS) |=> !ctrl_reg.en)
    else $error("stop match left counter running");
  a_single_rise: assert property (
    cycle_end && ctrl_reg.pwm && oen_reg[0] && !hit[1] |=> pwm_out[0])
    else $error("single edge output missed cycle start");
  a_single_fall: assert property (
    hit[1] && !cycle_end |=> !pwm_out[0] ##1 (!pwm_out[0] || $past(cycle_end)))
    else $error("single edge output not low after match");
  a_double_rise: assert property (
    ctrl_reg.pwm && oen_reg[1] && dbl_reg[1] && hit[1] && !hit[2] |=> pwm_out[1])
    else $error("double edge output missed rise");
  a_release_hold: assert property (
    ctrl_reg.pwm && !cycle_end |=> $stable(act_mem[1]))
    else $error("match value changed outside cycle start");
  a_timer_idle: assert property (
    !ctrl_reg.pwm |=> pwm_out == '0)
    else $error("output active outside pulse mode");
  a_capture_copy: assert property (
    cap_evt[0] |=> cap_mem[0] == $past(count_reg))
    else $error("capture did not copy count");
  a_flag_sticky: assert property (
    flag_reg[0] && !(wr_en && paddr == MPWM_FLAG_OFS) |=> flag_reg[0])
    else $error("flag dropped without clear");

  c_cycle: cover property (cycle_end ##[1:50] cycle_end);
  c_release: cover property (rel_reg[1] && cycle_end);
  c_capture: cover property (cap_evt[1]);
  c_double: cover property (dbl_reg[1] && pwm_out[1]);
endmodule : mpwm_timer

// ---- tb/mpwm_load.sv ----
// Load model on the pulse outputs: measures period and high time per output.
// Assumes outputs are synchronous to pclk; lengths are in pclk cycles.
`timescale 1ns/100ps
module mpwm_load
  import mpwm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [MPWM_OUT_N-1:0] pwm_out,
  output logic [MPWM_OUT_N-1:0][15:0] high_len,
  output logic [MPWM_OUT_N-1:0][15:0] per_len
);
  logic [MPWM_OUT_N-1:0] prev_reg;
  logic [MPWM_OUT_N-1:0][15:0] cyc_reg;
  logic [MPWM_OUT_N-1:0][15:0] hi_reg;

  // Latch lengths at each rising edge seen on an output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= '0;
      cyc_reg <= '0;
      hi_reg <= '0;
      high_len <= '0;
      per_len <= '0;
    end else begin
      prev_reg <= pwm_out;
      for (int i = 0; i < MPWM_OUT_N; i++) begin
        if (pwm_out[i] && !prev_reg[i]) begin
          per_len[i] <= cyc_reg[i];
          high_len[i] <= hi_reg[i];
          cyc_reg[i] <= 16'h0001;
          hi_reg[i] <= 16'h0001;
        end else begin
          cyc_reg[i] <= cyc_reg[i] + 16'h0001;
          hi_reg[i] <= hi_reg[i] + {15'h0000, pwm_out[i]};
        end
      end
    end
  end
endmodule : mpwm_load

// ---- tb/tb.sv ----
// Self-checking bench for the pulse modulator: APB tasks and directed tests.
// Assumes a zero-wait APB slave and the load model on the outputs.
`timescale 1ns/100ps
module tb
  import mpwm_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [MPWM_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [MPWM_CAP_N-1:0] cap_in = '0;
  logic sync_run_out;
  logic [MPWM_OUT_N-1:0] pwm_out;
  logic [MPWM_OUT_N-1:0][15:0] high_len;
  logic [MPWM_OUT_N-1:0][15:0] per_len;
  logic [31:0] rd;
  logic sync_run = 1'b1;
  logic err;
  int num_errors = 0;
  int cmp_count = 0;

  always #10 pclk = ~pclk;

  mpwm_timer u_mpwm_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cap_in(cap_in), .sync_run_in(sync_run), .sync_run_out(sync_run_out),
    .pwm_out(pwm_out));
  mpwm_load u_mpwm_load (.pclk(pclk), .presetn(presetn), .pwm_out(pwm_out),
    .high_len(high_len), .per_len(per_len));

  // Compare and count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One APB transfer; held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) check("pready", 32'h0000_0000, 32'h0000_0001);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(name, rd, exp);
  endtask : rchk

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : wait_cyc

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  // Watchdog well beyond the test length
  initial begin
    #(20 * 5000);
    num_errors++;
    wrap_up();
  end

  initial begin
    wait_cyc(10);
    presetn <= 1'b1;
    // Reset values and unmapped access
    rchk("ctrl", MPWM_CTRL_OFS, MPWM_WORD_RST);
    rchk("match0", MPWM_MATCH0_OFS, MPWM_WORD_RST);
    rchk("unmapped", 8'h80, 32'h0000_0000);
    check("pslverr", {31'h0000_0000, err}, 32'h0000_0001);
    $display("test reset done");
    // stop on match with flag, prescale of two
    apb(1'b1, MPWM_PLIM_OFS, 32'h0000_0001);
    apb(1'b1, MPWM_MATCH0_OFS + 8'h04, 32'h0000_0005);
    apb(1'b1, MPWM_MCTRL_OFS, 32'h0000_0028);
    apb(1'b1, MPWM_CTRL_OFS, 32'h0000_0001);
    wait_cyc(40);
    rchk("count stop", MPWM_COUNT_OFS, 32'h0000_0006);
    wait_cyc(10);
    rchk("count held", MPWM_COUNT_OFS, 32'h0000_0006);
    rchk("run cleared", MPWM_CTRL_OFS, 32'h0000_0000);
    rchk("match flag", MPWM_FLAG_OFS, 32'h0000_0002);
    apb(1'b1, MPWM_FLAG_OFS, 32'h0000_0002);
    rchk("flag clear", MPWM_FLAG_OFS, 32'h0000_0000);
    $display("test stop done");
    // capture on rising edge of input 0
    apb(1'b1, MPWM_CCTRL_OFS, 32'h0000_0005);
    cap_in <= 2'b01;
    wait_cyc(3);
    rchk("capture", MPWM_CAP0_OFS, 32'h0000_0006);
    rchk("cap flag", MPWM_FLAG_OFS, 32'h0000_0080);
    apb(1'b1, MPWM_FLAG_OFS, 32'h0000_0080);
    $display("test capture done");
    // counter mode on input 0 rising edges
    cap_in <= 2'b00;
    apb(1'b1, MPWM_CTRL_OFS, 32'h0000_0002);
    apb(1'b1, MPWM_CTRL_OFS, 32'h0000_0000);
    apb(1'b1, MPWM_PLIM_OFS, 32'h0000_0000);
    apb(1'b1, MPWM_CNT_OFS, 32'h0000_0001);
    apb(1'b1, MPWM_CTRL_OFS, 32'h0000_0001);
    repeat (3) begin
      cap_in <= 2'b01;
      wait_cyc(2);
      cap_in <= 2'b00;
      wait_cyc(2);
    end
    wait_cyc(20);
    rchk("edge count", MPWM_COUNT_OFS, 32'h0000_0003);
    // Both edges of input 1 as count clock
    apb(1'b1, MPWM_CNT_OFS, 32'h0000_0007);
    cap_in <= 2'b10;
    wait_cyc(2);
    cap_in <= 2'b00;
    wait_cyc(4);
    rchk("both edges", MPWM_COUNT_OFS, 32'h0000_0005);
    apb(1'b1, MPWM_CTRL_OFS, 32'h0000_0002);
    apb(1'b1, MPWM_CNT_OFS, 32'h0000_0000);
    apb(1'b1, MPWM_MCTRL_OFS, 32'h0000_0000);
    $display("test counter done");
    // single edge, period ten, edge at three
    apb(1'b1, MPWM_MATCH0_OFS, 32'h0000_0009);
    apb(1'b1, MPWM_MATCH0_OFS + 8'h04, 32'h0000_0003);
    apb(1'b1, MPWM_OCTRL_OFS, 32'h0000_0100);
    apb(1'b1, MPWM_CTRL_OFS, 32'h0000_0005);
    wait_cyc(40);
    check("period", {16'h0000, per_len[0]}, 32'h0000_000A);
    check("high", {16'h0000, high_len[0]}, 32'h0000_0004);
    check("run out", {31'h0000_0000, sync_run_out}, 32'h0000_0001);
    apb(1'b1, MPWM_MATCH0_OFS + 8'h04, 32'h0000_0006);
    wait_cyc(30);
    check("unreleased", {16'h0000, high_len[0]}, 32'h0000_0004);
    apb(1'b1, MPWM_REL_OFS, 32'h0000_0002);
    wait_cyc(40);
    check("released", {16'h0000, high_len[0]}, 32'h0000_0007);
    $display("test single done");
    // negative pulse on output two, rise at six, fall at two
    apb(1'b1, MPWM_MATCH0_OFS + 8'h08, 32'h0000_0002);
    apb(1'b1, MPWM_OCTRL_OFS, 32'h0000_0302);
    apb(1'b1, MPWM_REL_OFS, 32'h0000_0004);
    wait_cyc(40);
    check("dbl high", {16'h0000, high_len[1]}, 32'h0000_0006);
    check("dbl period", {16'h0000, per_len[1]}, 32'h0000_000A);
    check("out1 high", {16'h0000, high_len[0]}, 32'h0000_0007);
    apb(1'b1, MPWM_OCTRL_OFS, 32'h0000_0202);
    wait_cyc(30);
    check("out1 low", {31'h0000_0000, pwm_out[0]}, 32'h0000_0000);
    // pulse mode off forces outputs low
    apb(1'b1, MPWM_CTRL_OFS, 32'h0000_0001);
    wait_cyc(3);
    check("plain timer", {26'h0000_000, pwm_out}, 32'h0000_0000);
    $display("test double done");
    // follower counts only while the leader runs
    sync_run <= 1'b0;
    apb(1'b1, MPWM_CTRL_OFS, 32'h0000_0002);
    apb(1'b1, MPWM_CTRL_OFS, 32'h0000_0009);
    rchk("follower held", MPWM_COUNT_OFS, 32'h0000_0000);
    sync_run <= 1'b1;
    wait_cyc(4);
    sync_run <= 1'b0;
    rchk("follower run", MPWM_COUNT_OFS, 32'h0000_0004);
    $display("test follower done");
    wrap_up();
  end
endmodule : tb
